// >>> design/bcs_defines.svh
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH
// System clock and the one-second tick derived from it
`define BCS_CLK_HZ 20000000
`define BCS_TICK_S 1
`define BCS_TICK_CYCLES (`BCS_CLK_HZ * `BCS_TICK_S)
// Blink cadence, seconds high and seconds low
`define BCS_SOUND_HALF_S 2'd2
// Times in seconds, the MIN values in minutes; each tick is one second
`define BCS_STANDBY_S 16'd60
`define BCS_ILK_DELAY_MIN 16'd4
`define BCS_ILK_DELAY_S (`BCS_ILK_DELAY_MIN * 16'd60)
`define BCS_PURGE_MIN 16'd10
`define BCS_PURGE_S (`BCS_PURGE_MIN * 16'd60)
`define BCS_ILK_PUMP_ON_S 16'd30
`define BCS_ILK_FAN_EXTRA_S 16'd5
// Factory values
`define BCS_ILK_PUMP_PERIOD_S 16'd600
`define BCS_BURST_S 16'd20
`define BCS_FIRE_OUT_WAIT_S 16'd900
`define BCS_FAN_SCALE_S 16'd6
`define BCS_PUMP_ON_TEMP 8'd40
// Temperatures in degrees
`define BCS_PUMP_HYST 9'd4
`define BCS_FEED_OVERHEAT_TEMP 8'd98
`define BCS_OVERTEMP_LIMIT 8'd85
`define BCS_FIRE_DROP 9'd10
`define BCS_FIRE_RISE 9'd4
// Feed time limits in seconds
`define BCS_FEED_T_MIN 8'd5
`define BCS_FEED_T_MAX 8'd250
// Alarm numbers
`define BCS_OUTLET_SENSOR_FAULT_ALARM 3'h1
`define BCS_FEED_SENSOR_FAULT_ALARM 3'h2
`define BCS_HOT_WATER_SENSOR_FAULT_ALARM 3'h3
`define BCS_FIRE_OUT_ALARM 3'h5
`define BCS_FUEL_OVERHEAT_ALARM 3'h6
`endif

// >>> design/bcs_pkg.sv
package bcs_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000, ST_STANDBY = 3'b001, ST_MANUAL = 3'b010,
    ST_AUTO = 3'b011, ST_SUSTAIN = 3'b100, ST_ALARM = 3'b101
  } bcs_state_type;
  typedef enum logic [2:0] {
    DSP_DASHES = 3'b000, DSP_TEMP = 3'b001, DSP_BLO = 3'b010,
    DSP_ALARM = 3'b011, DSP_STANDBY = 3'b100, DSP_OVERTEMP = 3'b101
  } bcs_disp_type;
  typedef enum logic [1:0] {
    PM_MANUAL = 2'b00, PM_AUTO = 2'b01, PM_SUSTAIN = 2'b10
  } bcs_mode_type;
endpackage : bcs_pkg

// >>> design/bcs_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bcs_tick_if;
  logic sec;
  logic blink;
  modport src (output sec, output blink);
  modport dst (input sec, input blink);
endinterface : bcs_tick_if
`default_nettype wire

// >>> design/bcs_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"
module bcs_tick import bcs_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `BCS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Tick and blink out
  bcs_tick_if.src tk
);
  logic [24:0] cnt_q;
  logic [1:0] half_q;
  logic sec_q;
  logic blink_q;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= 25'h0;
      sec_q <= 1'b0;
    end else if (cnt_q == 25'(TICK_CYCLES - 1)) begin
      cnt_q <= 25'h0;
      sec_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 25'h1;
      sec_q <= 1'b0;
    end
  end

  // Square wave of two seconds high, two low, for blinking diodes and overtemperature text
  always_ff @(posedge clock) begin
    if (!rstn) begin
      half_q <= 2'h0;
      blink_q <= 1'b1;
    end else if (sec_q) begin
      if (half_q == `BCS_SOUND_HALF_S - 2'h1) begin
        half_q <= 2'h0;
        blink_q <= ~blink_q;
      end else begin
        half_q <= half_q + 2'h1;
      end
    end
  end

  assign tk.sec = sec_q;
  assign tk.blink = blink_q;
endmodule : bcs_tick
`default_nettype wire

// >>> design/bcs_sequencer.sv
// Function
// - Interlock in sustaining mode: heating pump off, interlock text shown.
// - Interlock in automatic: go sustaining, show text, pump off after four minutes.
// - Interlock burst still runs screw and fan; fan five seconds longer.
// - Interlock never ends programming mode.
// - During interlock run the pump 30 seconds every factory period.
// - Feed at 98 degrees: fuel overheat alarm, fan off, screw on ten minutes.
// - Enabled feed sensor faulty: same purge; sensor can be disabled.
// - Manual mode skips overheat check; feed sensor fault gives feed sensor alarm.
// - After power return wait one minute, then resume with stored parameters.
// - Standby shows remaining time and prior mode letter; mode diodes blink.
// - Standby end resumes manual off, automatic, or sustaining with a burst.
// - First power-up: dashes, outputs off, only on/off; then load parameters, manual.
// - Manual: feed and fan buttons toggle each output and its diode independently.
// - Manual button in automatic or sustaining stops everything, enters manual.
// - Automatic pump on at threshold, off at threshold minus 4.
// - Automatic feed cycle: load time on, stop time off, repeated.
// - Ten degree fall without 4 rise: pump off, wait, then fire-out unless interlock or water above the stored value.
// - Setpoint reached goes sustaining; at or below setpoint minus parameter returns automatic.
// - Sustain entry fan runs scaled time; each interval burst with extended fan.
// - Alarms except overtemperature: show number, sounder 2 s on/off, leave on button.
// - Above 85 alternate overtemperature text, pump on in manual, clears below 85.
// - Programming button enters programming, diode lit; manual and auto buttons ignored.
// - Outlet or hot water sensor fault in manual, automatic or sustaining, feed sensor fault in manual only: outputs off, sensor alarm shown, manual after ack.
// - Feed load and stop times limited to 5 to 250 seconds.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"
module bcs_sequencer import bcs_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `BCS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pushbuttons, one-cycle pulses
  input wire logic btn_onoff,
  input wire logic btn_manual,
  input wire logic btn_auto,
  input wire logic btn_feed,
  input wire logic btn_fan,
  input wire logic btn_prog,
  input wire logic btn_ack,
  input wire logic prog_done,
  // Power-fail resume information, sampled once after reset
  input wire logic resume_valid,
  input wire bcs_mode_type resume_mode,
  // Thermostat and sensors
  input wire logic thermostat,
  input wire logic [7:0] water_temp,
  input wire logic [7:0] feed_temp,
  input wire logic water_fault,
  input wire logic feed_fault,
  input wire logic hw_fault,
  input wire logic feed_sensor_en,
  // User parameters
  input wire logic [7:0] water_setpoint,
  input wire logic [7:0] setpoint_parameter,
  input wire logic [7:0] feed_load_time,
  input wire logic [7:0] feed_stop_time,
  input wire logic [7:0] sustain_interval,
  input wire logic [7:0] fan_extend_delay,
  input wire logic [3:0] fan_power_level,
  // Switched outputs
  output logic fan_q,
  output logic [3:0] fan_level_q,
  output logic screw_q,
  output logic pump_q,
  output logic sounder_q,
  // Display, diodes and parameter load strobe
  output bcs_disp_type disp_kind_q,
  output logic [7:0] disp_num_q,
  output bcs_mode_type disp_mode_q,
  output logic disp_blink_q,
  output logic led_fan_q,
  output logic led_screw_q,
  output logic led_auto_q,
  output logic led_sust_q,
  output logic led_prog_q,
  output logic led_pump_q,
  output logic param_load_q
);
  function automatic logic [7:0] clamp_s(input logic [7:0] t);
    if (t < `BCS_FEED_T_MIN) return `BCS_FEED_T_MIN;
    if (t > `BCS_FEED_T_MAX) return `BCS_FEED_T_MAX;
    return t;
  endfunction : clamp_s

  function automatic logic [15:0] mins_to_s(input logic [7:0] m);
    return {2'h0, m, 6'h00} - {6'h00, m, 2'h0};
  endfunction : mins_to_s

  bcs_tick_if tk ();
  bcs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rstn(rstn),
    .tk(tk)
  );
  logic sec;
  assign sec = tk.sec;

  bcs_state_type state_q, prev_q;
  bcs_mode_type rs_mode_q;
  logic boot_q, prog_q, fo_wait_q, ot_q, pump_hys_q, feed_on_q, man_scr_q, man_fan_q;
  logic [1:0] snd_q;
  logic [2:0] alarm_q;
  logic [7:0] ref_q, lo_q, store_q, feed_cnt_q;
  logic [15:0] tm_q, bscr_q, bfan_q, pdly_q, ilk_cnt_q, ilk_run_q, purge_q;
  logic running, auto_sus, sens_fault, purge_go, fan_d, scr_d, pump_d;

  assign running = state_q == ST_MANUAL || state_q == ST_AUTO || state_q == ST_SUSTAIN;
  assign auto_sus = state_q == ST_AUTO || state_q == ST_SUSTAIN;
  // Standby is excluded: sensors may read wrong while the supply settles
  assign sens_fault = running && (water_fault || hw_fault ||
                      (state_q == ST_MANUAL && feed_fault));
  assign purge_go = auto_sus && feed_sensor_en && purge_q == 16'h0 &&
                    (feed_fault || feed_temp >= `BCS_FEED_OVERHEAT_TEMP);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= ST_OFF;
      prev_q <= ST_OFF;
      boot_q <= 1'b0;
      rs_mode_q <= PM_MANUAL;
      alarm_q <= 3'h0;
      tm_q <= 16'h0;
      fo_wait_q <= 1'b0;
      ref_q <= 8'h0;
      lo_q <= 8'h0;
      store_q <= 8'h0;
      param_load_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
      prev_q <= state_q;
      param_load_q <= 1'b0;
      if (sens_fault) begin
        state_q <= ST_ALARM;
        alarm_q <= water_fault ? `BCS_OUTLET_SENSOR_FAULT_ALARM :
                   hw_fault ? `BCS_HOT_WATER_SENSOR_FAULT_ALARM :
                   `BCS_FEED_SENSOR_FAULT_ALARM;
      end else if (purge_go) begin
        state_q <= ST_ALARM;
        alarm_q <= `BCS_FUEL_OVERHEAT_ALARM;
      end else begin
        case (state_q)
          ST_OFF: begin
            if (!boot_q && resume_valid) begin
              state_q <= ST_STANDBY;
              rs_mode_q <= resume_mode;
              tm_q <= `BCS_STANDBY_S;
            end else if (boot_q && btn_onoff) begin
              state_q <= ST_MANUAL;
              param_load_q <= 1'b1;
            end
          end
          ST_STANDBY: begin
            if (sec && tm_q <= 16'h1) begin
              tm_q <= 16'h0;
              param_load_q <= 1'b1;
              case (rs_mode_q)
                PM_AUTO: state_q <= ST_AUTO;
                PM_SUSTAIN: begin
                  state_q <= ST_SUSTAIN;
                  tm_q <= mins_to_s(sustain_interval);
                end
                default: state_q <= ST_MANUAL;
              endcase
            end else if (sec) begin
              tm_q <= tm_q - 16'h1;
            end
          end
          ST_MANUAL: begin
            if (btn_auto && !prog_q) begin
              state_q <= ST_AUTO;
              fo_wait_q <= 1'b0;
              ref_q <= water_temp;
              lo_q <= water_temp;
            end
          end
          ST_AUTO: begin
            if (btn_manual && !prog_q) begin
              state_q <= ST_MANUAL;
            end else if (thermostat || water_temp >= water_setpoint) begin
              state_q <= ST_SUSTAIN;
              tm_q <= mins_to_s(sustain_interval);
              fo_wait_q <= 1'b0;
            end else if (thermostat) begin
              fo_wait_q <= 1'b0;
            end else if (sec && fo_wait_q) begin
              if (tm_q <= 16'h1) begin
                if (water_temp <= store_q) begin
                  state_q <= ST_ALARM;
                  alarm_q <= `BCS_FIRE_OUT_ALARM;
                end
                fo_wait_q <= 1'b0;
                ref_q <= water_temp;
                lo_q <= water_temp;
              end else begin
                tm_q <= tm_q - 16'h1;
              end
            end else if (sec) begin
              // A rise of more than the limit restarts the fall measurement
              if ({1'b0, water_temp} > {1'b0, lo_q} + `BCS_FIRE_RISE ||
                  water_temp > ref_q) begin
                ref_q <= water_temp;
                lo_q <= water_temp;
              end else if ({1'b0, water_temp} + `BCS_FIRE_DROP <= {1'b0, ref_q}) begin
                fo_wait_q <= 1'b1;
                store_q <= water_temp;
                tm_q <= `BCS_FIRE_OUT_WAIT_S;
              end else if (water_temp < lo_q) begin
                lo_q <= water_temp;
              end
            end
          end
          ST_SUSTAIN: begin
            if (btn_manual && !prog_q) begin
              state_q <= ST_MANUAL;
            end else if (!thermostat && {1'b0, water_temp} + {1'b0, setpoint_parameter}
                         <= {1'b0, water_setpoint}) begin
              state_q <= ST_AUTO;
              ref_q <= water_temp;
              lo_q <= water_temp;
            end else if (sec) begin
              tm_q <= (tm_q <= 16'h1) ? mins_to_s(sustain_interval) : tm_q - 16'h1;
            end
          end
          ST_ALARM: begin
            if (btn_ack) begin
              state_q <= ST_MANUAL;
            end
          end
          default: state_q <= ST_OFF;
        endcase
      end
    end
  end

  // Programming flag; the thermostat has no path into it
  always_ff @(posedge clock) begin
    if (!rstn) begin
      prog_q <= 1'b0;
    end else if (!running) begin
      prog_q <= 1'b0;
    end else if (btn_prog) begin
      prog_q <= 1'b1;
    end else if (prog_done) begin
      prog_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      man_scr_q <= 1'b0;
      man_fan_q <= 1'b0;
    end else if (state_q != ST_MANUAL) begin
      man_scr_q <= 1'b0;
      man_fan_q <= 1'b0;
    end else begin
      man_scr_q <= man_scr_q ^ btn_feed;
      man_fan_q <= man_fan_q ^ btn_fan;
    end
  end

  // Automatic feed cycle starts with a stop period
  always_ff @(posedge clock) begin
    if (!rstn) begin
      feed_on_q <= 1'b0;
      feed_cnt_q <= `BCS_FEED_T_MIN;
    end else if (state_q != ST_AUTO) begin
      feed_on_q <= 1'b0;
      feed_cnt_q <= clamp_s(feed_stop_time);
    end else if (sec && feed_cnt_q <= 8'h1) begin
      feed_on_q <= ~feed_on_q;
      feed_cnt_q <= feed_on_q ? clamp_s(feed_stop_time) : clamp_s(feed_load_time);
    end else if (sec) begin
      feed_cnt_q <= feed_cnt_q - 8'h1;
    end
  end

  // Sustain bursts and entry fan run
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bscr_q <= 16'h0;
      bfan_q <= 16'h0;
    end else if (state_q != ST_SUSTAIN) begin
      bscr_q <= 16'h0;
      bfan_q <= 16'h0;
    end else if ((prev_q == ST_STANDBY) || (sec && tm_q <= 16'h1)) begin
      bscr_q <= `BCS_BURST_S;
      bfan_q <= `BCS_BURST_S + (thermostat ? `BCS_ILK_FAN_EXTRA_S :
                                {8'h00, fan_extend_delay});
    end else if (prev_q != ST_SUSTAIN) begin
      bfan_q <= {12'h000, fan_power_level} * `BCS_FAN_SCALE_S;
    end else if (sec) begin
      bscr_q <= (bscr_q == 16'h0) ? 16'h0 : bscr_q - 16'h1;
      bfan_q <= (bfan_q == 16'h0) ? 16'h0 : bfan_q - 16'h1;
    end
  end

  // Cadence restarts at alarm entry; the first burst lasts one to two seconds as the tick is not reset
  always_ff @(posedge clock) begin
    if (!rstn || state_q != ST_ALARM) begin
      snd_q <= 2'h0;
    end else if (sec) begin
      snd_q <= snd_q + 2'h1;
    end
  end

  // Purge runs on through the alarm and after it is acknowledged
  always_ff @(posedge clock) begin
    if (!rstn) begin
      purge_q <= 16'h0;
    end else if (purge_go && !sens_fault) begin
      purge_q <= `BCS_PURGE_S;
    end else if (sec && purge_q != 16'h0) begin
      purge_q <= purge_q - 16'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pump_hys_q <= 1'b0;
      ot_q <= 1'b0;
    end else begin
      if (water_temp >= `BCS_PUMP_ON_TEMP) begin
        pump_hys_q <= 1'b1;
      end else if ({1'b0, water_temp} + `BCS_PUMP_HYST <= {1'b0, `BCS_PUMP_ON_TEMP}) begin
        pump_hys_q <= 1'b0;
      end
      if (water_temp > `BCS_OVERTEMP_LIMIT) begin
        ot_q <= 1'b1;
      end else if (water_temp < `BCS_OVERTEMP_LIMIT) begin
        ot_q <= 1'b0;
      end
    end
  end

  // Interlock pump delay and periodic circulation
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pdly_q <= 16'h0;
      ilk_cnt_q <= 16'h0;
      ilk_run_q <= 16'h0;
    end else if (!thermostat) begin
      pdly_q <= 16'h0;
      ilk_cnt_q <= 16'h0;
      ilk_run_q <= 16'h0;
    end else if (state_q == ST_AUTO) begin
      pdly_q <= `BCS_ILK_DELAY_S;
    end else if (sec) begin
      pdly_q <= (pdly_q == 16'h0) ? 16'h0 : pdly_q - 16'h1;
      ilk_run_q <= (ilk_run_q == 16'h0) ? 16'h0 : ilk_run_q - 16'h1;
      if (ilk_cnt_q >= `BCS_ILK_PUMP_PERIOD_S - 16'h1) begin
        ilk_cnt_q <= 16'h0;
        ilk_run_q <= `BCS_ILK_PUMP_ON_S;
      end else begin
        ilk_cnt_q <= ilk_cnt_q + 16'h1;
      end
    end
  end

  always_comb begin
    scr_d = 1'b0;
    fan_d = 1'b0;
    pump_d = 1'b0;
    case (state_q)
      ST_MANUAL: begin
        scr_d = man_scr_q;
        fan_d = man_fan_q;
        pump_d = ot_q;
      end
      ST_AUTO: begin
        scr_d = feed_on_q;
        fan_d = 1'b1;
        pump_d = pump_hys_q && !fo_wait_q;
      end
      ST_SUSTAIN: begin
        scr_d = bscr_q != 16'h0;
        fan_d = bfan_q != 16'h0;
        pump_d = thermostat ? ((pump_hys_q && pdly_q != 16'h0) || ilk_run_q != 16'h0) :
                 pump_hys_q;
      end
      default: begin
        scr_d = 1'b0;
        fan_d = 1'b0;
        pump_d = 1'b0;
      end
    endcase
    if (purge_q != 16'h0) begin
      scr_d = 1'b1;
      fan_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      fan_q <= 1'b0;
      fan_level_q <= 4'h0;
      screw_q <= 1'b0;
      pump_q <= 1'b0;
      sounder_q <= 1'b0;
    end else begin
      fan_q <= fan_d;
      fan_level_q <= fan_d ? fan_power_level : 4'h0;
      screw_q <= scr_d;
      pump_q <= pump_d;
      sounder_q <= state_q == ST_ALARM && !snd_q[1];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      disp_kind_q <= DSP_DASHES;
      disp_num_q <= 8'h00;
      disp_mode_q <= PM_MANUAL;
      disp_blink_q <= 1'b0;
      led_fan_q <= 1'b0;
      led_screw_q <= 1'b0;
      led_auto_q <= 1'b0;
      led_sust_q <= 1'b0;
      led_prog_q <= 1'b0;
      led_pump_q <= 1'b0;
    end else begin
      disp_mode_q <= rs_mode_q;
      disp_blink_q <= state_q == ST_STANDBY && rs_mode_q == PM_AUTO;
      led_fan_q <= fan_d;
      led_screw_q <= scr_d;
      led_prog_q <= prog_q;
      led_pump_q <= pump_d;
      led_auto_q <= state_q == ST_AUTO ||
                    (state_q == ST_STANDBY && rs_mode_q == PM_AUTO && tk.blink);
      led_sust_q <= state_q == ST_SUSTAIN ||
                    (state_q == ST_STANDBY && rs_mode_q == PM_SUSTAIN && tk.blink);
      disp_num_q <= water_temp;
      case (state_q)
        ST_OFF: disp_kind_q <= DSP_DASHES;
        ST_STANDBY: begin
          disp_kind_q <= DSP_STANDBY;
          disp_num_q <= tm_q[7:0];
        end
        ST_ALARM: begin
          disp_kind_q <= DSP_ALARM;
          disp_num_q <= {5'h00, alarm_q};
        end
        default: begin
          if (ot_q && tk.blink) begin
            disp_kind_q <= DSP_OVERTEMP;
          end else if (state_q == ST_SUSTAIN && thermostat) begin
            disp_kind_q <= DSP_BLO;
          end else begin
            disp_kind_q <= DSP_TEMP;
          end
        end
      endcase
    end
  end
endmodule : bcs_sequencer
`default_nettype wire

// >>> testbench/bcs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_chk import bcs_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Watched outputs
  input wire logic fan_q,
  input wire logic [3:0] fan_level_q,
  input wire logic screw_q,
  input wire logic pump_q,
  input wire logic sounder_q,
  input wire bcs_disp_type disp_kind_q,
  input wire logic [7:0] disp_num_q,
  input wire logic led_fan_q,
  input wire logic led_screw_q,
  input wire logic led_pump_q,
  input wire logic param_load_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence all_off;
    !fan_q && !screw_q && !pump_q;
  endsequence
  // Two seconds on spans far more than eight cycles at any usable tick
  sequence sound_on;
    (sounder_q || disp_kind_q != DSP_ALARM) [*8];
  endsequence
  fan_diode_a: assert property (led_fan_q == fan_q) else $error("fan diode differs");
  screw_diode_a: assert property (led_screw_q == screw_q) else $error("screw diode differs");
  pump_diode_a: assert property (led_pump_q == pump_q) else $error("pump diode differs");
  fan_level_a: assert property (!fan_q |-> fan_level_q == 4'h0) else $error("level with fan off");
  load_pulse_a: assert property (param_load_q |=> !param_load_q) else $error("load strobe long");
  reset_off_a: assert property ($rose(rstn) |-> all_off ##0 disp_kind_q == DSP_DASHES)
    else $error("outputs on after reset");
  dashes_off_a: assert property (disp_kind_q == DSP_DASHES |-> all_off) else $error("on while off");
  standby_off_a: assert property (disp_kind_q == DSP_STANDBY |-> all_off) else $error("on in standby");
  sound_cadence_a: assert property ($rose(sounder_q) |=> sound_on) else $error("sounder pulse short");
  sound_alarm_a: assert property (sounder_q |-> disp_kind_q == DSP_ALARM) else $error("stray sounder");
  purge_fan_a: assert property (disp_kind_q == DSP_ALARM && disp_num_q == 8'h06 |-> !fan_q)
    else $error("fan on in purge");
endmodule : bcs_chk
bind bcs_sequencer bcs_chk chk (.clock(clock), .rstn(rstn), .fan_q(fan_q),
  .fan_level_q(fan_level_q), .screw_q(screw_q), .pump_q(pump_q), .sounder_q(sounder_q),
  .disp_kind_q(disp_kind_q), .disp_num_q(disp_num_q), .led_fan_q(led_fan_q),
  .led_screw_q(led_screw_q), .led_pump_q(led_pump_q), .param_load_q(param_load_q));
`default_nettype wire

// >>> testbench/bcs_plant.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_plant (
  // Clock
  input wire logic clock,
  // Conditions chosen by the bench
  input wire logic [7:0] want_water,
  input wire logic [7:0] want_feed,
  input wire logic want_thermo,
  input wire logic [1:0] want_fault,
  // Sensor and thermostat lines
  output logic [7:0] water_temp = 8'h00,
  output logic [7:0] feed_temp = 8'h00,
  output logic thermostat = 1'b0,
  output logic water_fault = 1'b0,
  output logic feed_fault = 1'b0
);
  // Readings change away from the sampling edge, as a slow sensor would
  always @(negedge clock) begin
    water_temp <= want_water;
    feed_temp <= want_feed;
    thermostat <= want_thermo;
    water_fault <= want_fault[0];
    feed_fault <= want_fault[1];
  end
endmodule : bcs_plant
`default_nettype wire

// >>> testbench/boiler_combustion_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module boiler_combustion_sequencer_test;
  import bcs_pkg::*;
  localparam int TK = 10;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] btn = 8'h00;
  logic rv = 1'b0;
  bcs_mode_type rm = PM_AUTO;
  logic sen = 1'b1;
  logic [7:0] ww = 8'h32, wf = 8'h14, lt = 8'h05, stt = 8'h05;
  logic [3:0] pw = 4'h7;
  logic wth = 1'b0;
  logic [1:0] wfl = 2'b00;
  logic [7:0] water_temp, feed_temp, disp_num_q;
  logic thermostat, water_fault, feed_fault;
  logic fan_q, screw_q, pump_q, sounder_q, disp_blink_q, param_load_q;
  logic led_fan_q, led_screw_q, led_auto_q, led_sust_q, led_prog_q, led_pump_q;
  logic [3:0] fan_level_q;
  bcs_disp_type disp_kind_q;
  bcs_mode_type disp_mode_q;
  int n_fail = 0;
  int num_checks = 0;
  always #25 clock = ~clock;
  bcs_plant plant (.clock(clock), .want_water(ww), .want_feed(wf), .want_thermo(wth),
    .want_fault(wfl), .water_temp(water_temp), .feed_temp(feed_temp),
    .thermostat(thermostat), .water_fault(water_fault), .feed_fault(feed_fault));
  bcs_sequencer #(.TICK_CYCLES(TK)) uut (.clock(clock), .rstn(rstn), .btn_onoff(btn[0]),
    .btn_manual(btn[1]), .btn_auto(btn[2]), .btn_feed(btn[3]), .btn_fan(btn[4]),
    .btn_prog(btn[5]), .btn_ack(btn[6]), .prog_done(btn[7]), .resume_valid(rv),
    .resume_mode(rm), .thermostat(thermostat), .water_temp(water_temp),
    .feed_temp(feed_temp), .water_fault(water_fault), .feed_fault(feed_fault),
    .hw_fault(1'b0), .feed_sensor_en(sen), .water_setpoint(8'h46),
    .setpoint_parameter(8'h05), .feed_load_time(lt), .feed_stop_time(stt),
    .sustain_interval(8'h05), .fan_extend_delay(8'h05), .fan_power_level(pw),
    .fan_q(fan_q), .fan_level_q(fan_level_q), .screw_q(screw_q), .pump_q(pump_q),
    .sounder_q(sounder_q), .disp_kind_q(disp_kind_q), .disp_num_q(disp_num_q),
    .disp_mode_q(disp_mode_q), .disp_blink_q(disp_blink_q), .led_fan_q(led_fan_q),
    .led_screw_q(led_screw_q), .led_auto_q(led_auto_q), .led_sust_q(led_sust_q),
    .led_prog_q(led_prog_q), .led_pump_q(led_pump_q), .param_load_q(param_load_q));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic kind(input bcs_disp_type e);
    check("kind", 8'(disp_kind_q), 8'(e));
  endtask : kind
  // Pulse lasts one cycle; returns once the two-edge answer has landed
  task automatic press(input int i);
    @(negedge clock) btn[i] = 1'b1;
    @(negedge clock) btn[i] = 1'b0;
    repeat (2) @(negedge clock);
  endtask : press
  task automatic secs(input int n);
    repeat (n * TK) @(negedge clock);
  endtask : secs
  task automatic t_boot;
    kind(DSP_DASHES);
    press(4);
    check("fan", fan_q, 1'b0);
    @(negedge clock) btn[0] = 1'b1;
    @(negedge clock) btn[0] = 1'b0;
    check("load", param_load_q, 1'b1);
    repeat (2) @(negedge clock);
    kind(DSP_TEMP);
    $display("boot done");
  endtask : t_boot
  task automatic t_manual;
    press(3);
    check("screw", screw_q, 1'b1);
    check("fan", fan_q, 1'b0);
    press(4);
    press(3);
    check("screw", screw_q, 1'b0);
    check("fan", fan_q, 1'b1);
    check("level", fan_level_q, pw);
    press(4);
    check("fan", fan_q, 1'b0);
    $display("manual done");
  endtask : t_manual
  task automatic t_auto;
    ww = 8'h2c;
    press(2);
    check("auto", led_auto_q, 1'b1);
    check("pump", pump_q, 1'b1);
    secs(2);
    check("stop", screw_q, 1'b0);
    secs(5);
    check("load", screw_q, 1'b1);
    secs(5);
    check("stop", screw_q, 1'b0);
    ww = 8'h25;
    secs(1);
    check("pump", pump_q, 1'b1);
    ww = 8'h24;
    secs(1);
    check("pump", pump_q, 1'b0);
    ww = 8'h2c;
    secs(1);
    ww = 8'h46;
    secs(1);
    wth = 1'b1;
    secs(1);
    check("sust", led_sust_q, 1'b1);
    check("pump", pump_q, 1'b0);
    kind(DSP_BLO);
    wth = 1'b0;
    press(1);
    check("all", {fan_q, screw_q, pump_q, led_auto_q}, 8'h00);
    $display("auto done");
  endtask : t_auto
  task automatic t_over;
    int hi = 0;
    int lo = 0;
    ww = 8'h5a;
    repeat (6 * TK) begin
      @(negedge clock);
      hi += (disp_kind_q === DSP_OVERTEMP);
      lo += (disp_kind_q === DSP_TEMP);
    end
    check("alternate", 8'(hi > 0 && lo > 0), 8'h01);
    check("pump", pump_q, 1'b1);
    ww = 8'h54;
    secs(3);
    kind(DSP_TEMP);
    $display("overtemp done");
  endtask : t_over
  task automatic t_alarm;
    int on = 0;
    ww = 8'h32;
    press(2);
    wfl = 2'b01;
    secs(1);
    check("all", {fan_q, screw_q, pump_q}, 8'h00);
    kind(DSP_ALARM);
    check("num", disp_num_q, 8'h01);
    repeat (8 * TK) begin
      @(negedge clock);
      on += (sounder_q === 1'b1);
    end
    check("sound", 8'(on), 8'h28);
    wfl = 2'b00;
    secs(2);
    kind(DSP_ALARM);
    press(6);
    kind(DSP_TEMP);
    $display("alarm done");
  endtask : t_alarm
  task automatic t_prog;
    press(5);
    check("prog", led_prog_q, 1'b1);
    press(2);
    check("auto", led_auto_q, 1'b0);
    press(7);
    check("prog", led_prog_q, 1'b0);
    $display("prog done");
  endtask : t_prog
  task automatic t_purge;
    press(2);
    wf = 8'h62;
    secs(1);
    check("num", disp_num_q, 8'h06);
    check("fan", fan_q, 1'b0);
    check("screw", screw_q, 1'b1);
    wf = 8'h14;
    secs(568);
    check("screw", screw_q, 1'b1);
    secs(40);
    check("screw", screw_q, 1'b0);
    press(6);
    $display("purge done");
  endtask : t_purge
  task automatic t_resume;
    rv = 1'b1;
    rstn = 1'b0;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    secs(1);
    kind(DSP_STANDBY);
    check("mode", 8'(disp_mode_q), 8'(PM_AUTO));
    check("left", 8'(disp_num_q inside {[8'h3a : 8'h3c]}), 8'h01);
    rv = 1'b0;
    secs(57);
    kind(DSP_STANDBY);
    secs(4);
    kind(DSP_TEMP);
    check("auto", led_auto_q, 1'b1);
    $display("resume done");
  endtask : t_resume
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
    t_boot();
    t_manual();
    t_auto();
    t_over();
    t_alarm();
    t_prog();
    t_purge();
    t_resume();
    conclude();
  end
  initial begin
    repeat (12000) @(posedge clock);
    n_fail++;
    $display("[FAIL] watchdog expected end seen hang");
    conclude();
  end
endmodule : boiler_combustion_sequencer_test
`default_nettype wire
